// [include/als_pkg.sv]
// Purpose: shared constants and types for the sixteen bit alu slice
// Assumes: 32-bit apb data, one word per register
// Notes: field codes follow the microinstruction encoding of the slice
`default_nettype none
package als_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 4;
  localparam int DEPTH = 16;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_WORK = 8'h0C;

  // ctrl field positions and reset value
  localparam int CTRL_STORE_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [15:0] WORK_RESET = 16'h0000;

  // status field positions
  localparam int ST_CARRY_BIT = 0;
  localparam int ST_OVF_BIT = 1;
  localparam int ST_ZERO_BIT = 2;
  localparam int ST_SIGN_BIT = 3;
  localparam int ST_PROP_N_BIT = 4;
  localparam int ST_GEN_N_BIT = 5;

  // source codes: (r,s)
  localparam logic [2:0] SRC_AQ = 3'h0;
  localparam logic [2:0] SRC_AB = 3'h1;
  localparam logic [2:0] SRC_ZQ = 3'h2;
  localparam logic [2:0] SRC_ZB = 3'h3;
  localparam logic [2:0] SRC_ZA = 3'h4;
  localparam logic [2:0] SRC_DA = 3'h5;
  localparam logic [2:0] SRC_DQ = 3'h6;
  localparam logic [2:0] SRC_DZ = 3'h7;

  // function codes
  localparam logic [2:0] FN_ADD = 3'h0;
  localparam logic [2:0] FN_SUBR = 3'h1;
  localparam logic [2:0] FN_SUBS = 3'h2;
  localparam logic [2:0] FN_OR = 3'h3;
  localparam logic [2:0] FN_AND = 3'h4;
  localparam logic [2:0] FN_NOTRS = 3'h5;
  localparam logic [2:0] FN_XOR = 3'h6;
  localparam logic [2:0] FN_XNOR = 3'h7;

  // destination codes
  localparam logic [2:0] DST_WORK = 3'h0;
  localparam logic [2:0] DST_NOP = 3'h1;
  localparam logic [2:0] DST_FILE_BYPASS = 3'h2;
  localparam logic [2:0] DST_FILE = 3'h3;
  localparam logic [2:0] DST_DOWN_BOTH = 3'h4;
  localparam logic [2:0] DST_DOWN = 3'h5;
  localparam logic [2:0] DST_UP_BOTH = 3'h6;
  localparam logic [2:0] DST_UP = 3'h7;

  typedef enum logic [1:0] {SH_NONE, SH_DOWN, SH_UP} als_shift_type;

  typedef struct packed {
    logic [2:0] destination_field;
    logic [2:0] function_select_field;
    logic [2:0] operand_source_field;
  } als_micro_type;
endpackage : als_pkg
`default_nettype wire

// [rtl/als_slice.sv]
// Purpose: sixteen bit cascadable alu slice with register file and work register
// Assumes: sequencer drives fields on pclk; apb gives store gate and status view
// Notes: operands are latched while pclk is high so writeback sees stable inputs
`timescale 1ns/1ps
`default_nettype none
module als_slice (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] read_select_first,
  input wire logic [3:0] read_write_select_second,
  input wire als_pkg::als_micro_type micro,
  input wire logic [15:0] data_in,
  input wire logic carry_in,
  input wire logic output_enable_n,
  output logic [15:0] result_bus_out_o,
  output logic result_bus_out_oe,
  output logic carry_out,
  output logic carry_gen_n,
  output logic carry_prop_n,
  output logic overflow_flag,
  output logic result_sign_out,
  output logic zero_detect_o,
  output logic zero_detect_oe,
  input wire logic file_low_shift_pin_i,
  output logic file_low_shift_pin_o,
  output logic file_low_shift_pin_oe,
  input wire logic file_high_shift_pin_i,
  output logic file_high_shift_pin_o,
  output logic file_high_shift_pin_oe,
  input wire logic work_low_shift_pin_i,
  output logic work_low_shift_pin_o,
  output logic work_low_shift_pin_oe,
  input wire logic work_high_shift_pin_i,
  output logic work_high_shift_pin_o,
  output logic work_high_shift_pin_oe
);
  logic [15:0] file_mem [als_pkg::DEPTH];
  logic [15:0] port_a, port_b, latch_a, latch_b;
  logic [15:0] work_reg;
  logic [31:0] ctrl_reg;
  logic [15:0] r_op, s_op, r_eff, s_eff, f;
  logic [15:0] gen, prop;
  logic [16:0] carry;
  logic arith;
  logic store_en;
  logic file_we, work_we;
  logic [15:0] file_next, work_next;
  logic [2:0] src, fn, dst;
  als_pkg::als_shift_type file_sh, work_sh;

  assign src = micro.operand_source_field;
  assign fn = micro.function_select_field;
  assign dst = micro.destination_field;
  assign store_en = ctrl_reg[als_pkg::CTRL_STORE_EN_BIT];

  // file shift direction from the destination code
  function automatic als_pkg::als_shift_type file_shift(input logic [2:0] d);
    if (d == als_pkg::DST_DOWN_BOTH || d == als_pkg::DST_DOWN) begin
      file_shift = als_pkg::SH_DOWN;
    end else if (d == als_pkg::DST_UP_BOTH || d == als_pkg::DST_UP) begin
      file_shift = als_pkg::SH_UP;
    end else begin
      file_shift = als_pkg::SH_NONE;
    end
  endfunction : file_shift

  // lookahead carry into position i, flattened instead of rippled
  function automatic logic carry_into(input logic [15:0] g, input logic [15:0] p,
                                      input logic cin, input int i);
    logic c;
    logic pp;
    c = 1'b0;
    pp = 1'b1;
    for (int j = i - 1; j >= 0; j--) begin
      c = c | (pp & g[j]);
      pp = pp & p[j];
    end
    carry_into = c | (pp & cin);
  endfunction : carry_into

  // register file read ports
  assign port_a = file_mem[read_select_first];
  assign port_b = file_mem[read_write_select_second];

  // operand latches: open on the low phase, held through the writing edge
  always_latch begin
    if (!pclk) begin
      latch_a <= port_a;
      latch_b <= port_b;
    end
  end

  // operand selection
  always_comb begin
    case (src)
      als_pkg::SRC_AQ: begin r_op = latch_a; s_op = work_reg; end
      als_pkg::SRC_AB: begin r_op = latch_a; s_op = latch_b; end
      als_pkg::SRC_ZQ: begin r_op = 16'h0000; s_op = work_reg; end
      als_pkg::SRC_ZB: begin r_op = 16'h0000; s_op = latch_b; end
      als_pkg::SRC_ZA: begin r_op = 16'h0000; s_op = latch_a; end
      als_pkg::SRC_DA: begin r_op = data_in; s_op = latch_a; end
      als_pkg::SRC_DQ: begin r_op = data_in; s_op = work_reg; end
      default: begin r_op = data_in; s_op = 16'h0000; end
    endcase
  end

  // subtract is ones' complement of one operand; carry-in completes two's
  assign arith = (fn == als_pkg::FN_ADD) || (fn == als_pkg::FN_SUBR) ||
                 (fn == als_pkg::FN_SUBS);
  assign r_eff = (fn == als_pkg::FN_SUBR) ? ~r_op : r_op;
  assign s_eff = (fn == als_pkg::FN_SUBS) ? ~s_op : s_op;
  assign gen = r_eff & s_eff;
  assign prop = r_eff | s_eff;

  genvar gi;
  generate
    for (gi = 0; gi <= 16; gi++) begin : g_carry
      assign carry[gi] = carry_into(gen, prop, carry_in, gi);
    end
  endgenerate

  always_comb begin
    case (fn)
      als_pkg::FN_ADD, als_pkg::FN_SUBR, als_pkg::FN_SUBS:
        f = r_eff ^ s_eff ^ carry[15:0];
      als_pkg::FN_OR: f = r_op | s_op;
      als_pkg::FN_AND: f = r_op & s_op;
      als_pkg::FN_NOTRS: f = ~r_op & s_op;
      als_pkg::FN_XOR: f = r_op ^ s_op;
      default: f = ~(r_op ^ s_op);
    endcase
  end

  // status outputs; logic functions force the carry group inactive
  assign carry_out = arith & carry[16];
  assign overflow_flag = arith & (carry[16] ^ carry[15]);
  assign carry_prop_n = ~arith | ~(&prop);
  assign carry_gen_n = ~arith | ~carry_into(gen, prop, 1'b0, 16);
  assign result_sign_out = f[15];
  // open drain: pulls low when any bit set, released (wire reads high) when zero
  assign zero_detect_o = 1'b0;
  assign zero_detect_oe = |f;

  // result bus
  assign result_bus_out_o = (dst == als_pkg::DST_FILE_BYPASS) ? latch_a : f;
  assign result_bus_out_oe = ~output_enable_n;

  // destination decode and shifters
  assign file_sh = file_shift(dst);
  assign file_we = store_en && (dst != als_pkg::DST_WORK) &&
                   (dst != als_pkg::DST_NOP);
  assign work_we = store_en && ((dst == als_pkg::DST_WORK) ||
                   (dst == als_pkg::DST_DOWN_BOTH) || (dst == als_pkg::DST_UP_BOTH));
  assign work_sh = (dst == als_pkg::DST_DOWN_BOTH) ? als_pkg::SH_DOWN :
                   (dst == als_pkg::DST_UP_BOTH) ? als_pkg::SH_UP : als_pkg::SH_NONE;

  always_comb begin
    case (file_sh)
      als_pkg::SH_DOWN: file_next = {file_high_shift_pin_i, f[15:1]};
      als_pkg::SH_UP: file_next = {f[14:0], file_low_shift_pin_i};
      default: file_next = f;
    endcase
  end

  always_comb begin
    case (work_sh)
      als_pkg::SH_DOWN: work_next = {work_high_shift_pin_i, work_reg[15:1]};
      als_pkg::SH_UP: work_next = {work_reg[14:0], work_low_shift_pin_i};
      default: work_next = f;
    endcase
  end

  // shift pin drivers: outputs only in the direction the table drives them
  assign file_low_shift_pin_o = f[0];
  assign file_low_shift_pin_oe = (file_sh == als_pkg::SH_DOWN);
  assign file_high_shift_pin_o = f[15];
  assign file_high_shift_pin_oe = (file_sh == als_pkg::SH_UP);
  assign work_low_shift_pin_o = work_reg[0];
  assign work_low_shift_pin_oe = (file_sh == als_pkg::SH_DOWN);
  assign work_high_shift_pin_o = work_reg[15];
  assign work_high_shift_pin_oe = (file_sh == als_pkg::SH_UP);

  // storage; the file is plain memory with no reset, like the original array
  always_ff @(posedge pclk) begin
    if (file_we) begin
      file_mem[read_write_select_second] <= file_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_reg <= als_pkg::WORK_RESET;
    end else if (work_we) begin
      work_reg <= work_next;
    end
  end

  // apb slave, zero wait states; ctrl bit gates every store
  logic apb_wr, apb_rd, mapped;
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;
  assign mapped = (paddr[7:0] == als_pkg::OFS_CTRL) || (paddr[7:0] == als_pkg::OFS_STATUS) ||
                  (paddr[7:0] == als_pkg::OFS_RESULT) || (paddr[7:0] == als_pkg::OFS_WORK);
  assign pslverr = psel && penable && (!mapped || paddr[31:8] != 24'h000000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= als_pkg::CTRL_RESET;
    end else if (apb_wr && paddr == {24'h000000, als_pkg::OFS_CTRL} && pstrb[0]) begin
      ctrl_reg <= {31'h00000000, pwdata[als_pkg::CTRL_STORE_EN_BIT]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_rd && !penable) begin
      case (paddr)
        {24'h000000, als_pkg::OFS_CTRL}: prdata <= ctrl_reg;
        {24'h000000, als_pkg::OFS_STATUS}: begin
          prdata <= 32'h00000000;
          prdata[als_pkg::ST_CARRY_BIT] <= carry_out;
          prdata[als_pkg::ST_OVF_BIT] <= overflow_flag;
          prdata[als_pkg::ST_ZERO_BIT] <= ~zero_detect_oe;
          prdata[als_pkg::ST_SIGN_BIT] <= result_sign_out;
          prdata[als_pkg::ST_PROP_N_BIT] <= carry_prop_n;
          prdata[als_pkg::ST_GEN_N_BIT] <= carry_gen_n;
        end
        {24'h000000, als_pkg::OFS_RESULT}: prdata <= {16'h0000, f};
        {24'h000000, als_pkg::OFS_WORK}: prdata <= {16'h0000, work_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // checks
  a_port_same: assert property (@(posedge pclk) disable iff (!presetn)
    (read_select_first == read_write_select_second) |-> (port_a == port_b))
    else $error("read ports differ on equal addresses");

  a_file_store: assert property (@(posedge pclk) disable iff (!presetn)
    (file_we && file_sh == als_pkg::SH_NONE) |=>
    (file_mem[$past(read_write_select_second)] == $past(f)))
    else $error("file word not written with result");

  a_up_store: assert property (@(posedge pclk) disable iff (!presetn)
    (file_we && file_sh == als_pkg::SH_UP) |=>
    (file_mem[$past(read_write_select_second)] ==
     {$past(f[14:0]), $past(file_low_shift_pin_i)}))
    else $error("up shift store wrong");

  a_work_load: assert property (@(posedge pclk) disable iff (!presetn)
    (store_en && dst == als_pkg::DST_WORK) |=> (work_reg == $past(f)))
    else $error("work register missed result");

  a_nop_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (dst == als_pkg::DST_NOP || dst == als_pkg::DST_FILE) |=> $stable(work_reg))
    else $error("work register changed without load");

  a_add_sum: assert property (@(posedge pclk) disable iff (!presetn)
    (fn == als_pkg::FN_ADD) |-> ({carry_out, f} == 17'(r_op) + 17'(s_op) + 17'(carry_in)))
    else $error("add result wrong");

  a_logic_flags: assert property (@(posedge pclk) disable iff (!presetn)
    (!arith) |-> (!carry_out && !overflow_flag && carry_prop_n && carry_gen_n))
    else $error("logic function status wrong");

  a_bus_bypass: assert property (@(posedge pclk) disable iff (!presetn)
    (dst == als_pkg::DST_FILE_BYPASS) |-> (result_bus_out_o == latch_a))
    else $error("bus does not bypass port a");

  a_zero_pull: assert property (@(posedge pclk) disable iff (!presetn)
    (f == 16'h0000) |-> !zero_detect_oe)
    else $error("zero output pulled on zero result");

  a_down_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (file_sh == als_pkg::SH_DOWN) |-> (file_low_shift_pin_oe && file_low_shift_pin_o == f[0]))
    else $error("low shift pin not driving lsb");
endmodule : als_slice
`default_nettype wire

// [test/als_seq_model.sv]
// Purpose: sequencer model that drives microinstructions, addresses, data and carry-in
// Assumes: one instruction per pclk, changed just after the rising edge
// Notes: the caller picks carry-in, so subtract tests can run ones' and two's complement
`timescale 1ns/1ps
`default_nettype none
module als_seq_model (
  input wire logic pclk,
  output logic [3:0] read_select_first,
  output logic [3:0] read_write_select_second,
  output var als_pkg::als_micro_type micro,
  output logic [15:0] data_in,
  output logic carry_in
);
  initial begin
    read_select_first = 4'h0;
    // differs from the first address so the never-written word 0 is not compared
    read_write_select_second = 4'h1;
    micro = {als_pkg::DST_NOP, als_pkg::FN_OR, als_pkg::SRC_DZ};
    data_in = 16'h0000;
    carry_in = 1'b0;
  end
  // fields stay put for the whole cycle so the low phase sees stable addresses
  task automatic issue(input logic [3:0] a, input logic [3:0] b, input logic [8:0] f,
    input logic [15:0] d, input logic c);
    @(posedge pclk);
    read_select_first <= a;
    read_write_select_second <= b;
    micro <= f;
    data_in <= d;
    carry_in <= c;
  endtask : issue
endmodule : als_seq_model
`default_nettype wire

// [test/sixteen_bit_alu_slice_tb.sv]
// Purpose: self-checking bench for the alu slice
// Assumes: results sampled in the low phase while operand latches are open
// Notes: every store sequence ends with a nop so a held field cannot store twice
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin errors++; \
  $display("ERROR %s expected %h got %h", nm, ex, got); end end
module sixteen_bit_alu_slice_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, output_enable_n;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] a_sel, b_sel, pin_i, pin_o, pin_oe, pin_drv;
  als_pkg::als_micro_type micro;
  logic [15:0] data_in, bus;
  logic [15:0] rv [16];
  logic carry_in, carry_out, gen_n, prop_n, ovf, sign, bus_oe, z_o, z_oe, zero;
  int errors, num_checks;
  assign zero = z_oe ? z_o : 1'b1;
  // pins: 0 file low, 1 file high, 2 work low, 3 work high
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & pin_drv);
  als_seq_model i_seq (.pclk(pclk), .read_select_first(a_sel),
    .read_write_select_second(b_sel), .micro(micro), .data_in(data_in), .carry_in(carry_in));
  als_slice i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .read_select_first(a_sel),
    .read_write_select_second(b_sel), .micro(micro), .data_in(data_in), .carry_in(carry_in),
    .output_enable_n(output_enable_n), .result_bus_out_o(bus), .result_bus_out_oe(bus_oe),
    .carry_out(carry_out), .carry_gen_n(gen_n), .carry_prop_n(prop_n), .overflow_flag(ovf),
    .result_sign_out(sign), .zero_detect_o(z_o), .zero_detect_oe(z_oe),
    .file_low_shift_pin_i(pin_i[0]), .file_low_shift_pin_o(pin_o[0]),
    .file_low_shift_pin_oe(pin_oe[0]), .file_high_shift_pin_i(pin_i[1]),
    .file_high_shift_pin_o(pin_o[1]), .file_high_shift_pin_oe(pin_oe[1]),
    .work_low_shift_pin_i(pin_i[2]), .work_low_shift_pin_o(pin_o[2]),
    .work_low_shift_pin_oe(pin_oe[2]), .work_high_shift_pin_i(pin_i[3]),
    .work_high_shift_pin_o(pin_o[3]), .work_high_shift_pin_oe(pin_oe[3]));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // returns {carry out, overflow, result}
  function automatic logic [17:0] alu_ref(input logic [2:0] fn, input logic [15:0] r,
    input logic [15:0] s, input logic c);
    logic [16:0] sum;
    logic [15:0] lo;
    if (fn > 3'h2) return {2'b00, fn == 3'h3 ? r | s : fn == 3'h4 ? r & s :
      fn == 3'h5 ? ~r & s : fn == 3'h6 ? r ^ s : ~(r ^ s)};
    if (fn == 3'h1) r = ~r;
    if (fn == 3'h2) s = ~s;
    sum = r + s + c;
    lo = {1'b0, r[14:0]} + {1'b0, s[14:0]} + c;
    return {sum[16], sum[16] ^ lo[15], sum[15:0]};
  endfunction : alu_ref
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h000000, addr};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the watchdog may end a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run(input logic [3:0] a, input logic [3:0] b, input logic [2:0] src,
    input logic [2:0] fn, input logic [2:0] dst, input logic [15:0] d, input logic c);
    i_seq.issue(a, b, {dst, fn, src}, d, c);
    @(negedge pclk);
    #2;
  endtask : run
  task automatic rd_file(input logic [3:0] x, input logic [15:0] ex);
    run(x, 4'h0, 3'h4, 3'h0, 3'h1, 16'h0000, 1'b0);
    `CHK("file word", ex, bus);
  endtask : rd_file
  task automatic chk_alu(input logic [2:0] fn, input logic [15:0] r, input logic [15:0] s,
    input logic c);
    logic [17:0] e;
    logic [17:0] g;
    logic [15:0] p;
    e = alu_ref(fn, r, s, c);
    g = alu_ref(fn, r, s, 1'b0);
    // group propagate from the operands as the subtract functions present them
    p = (fn == 3'h1 ? ~r : r) | (fn == 3'h2 ? ~s : s);
    `CHK("result", e[15:0], bus);
    `CHK("carry", e[17], carry_out);
    `CHK("overflow", e[16], ovf);
    `CHK("sign", e[15], sign);
    `CHK("zero", e[15:0] == 16'h0000, zero);
    `CHK("gen_n", fn > 3'h2 ? 1'b1 : ~g[17], gen_n);
    `CHK("prop_n", fn > 3'h2 ? 1'b1 : ~&p, prop_n);
  endtask : chk_alu
  task automatic test_alu();
    logic [31:0] pairs;
    logic [3:0] a;
    logic [3:0] b;
    pairs = 32'h1233_1342;
    for (int i = 1; i < 5; i++) run(4'h0, i[3:0], 3'h7, 3'h3, 3'h3, rv[i], 1'b0);
    for (int i = 1; i < 5; i++) rd_file(i[3:0], rv[i]);
    for (int k = 0; k < 4; k++) begin
      a = pairs[8*k+4 +: 4];
      b = pairs[8*k +: 4];
      for (int fn = 0; fn < 8; fn++) begin
        for (int c = 0; c < 2; c++) begin
          run(a, b, 3'h1, fn[2:0], 3'h1, 16'h0000, c[0]);
          chk_alu(fn[2:0], rv[a], rv[b], c[0]);
        end
      end
    end
  endtask : test_alu
  task automatic test_src();
    logic [15:0] r;
    logic [15:0] s;
    // second address 1 keeps the never-written word 0 off the equal-address path
    run(4'h0, 4'h1, 3'h7, 3'h3, 3'h0, 16'h1357, 1'b0);
    for (int k = 0; k < 8; k++) begin
      run(4'h4, 4'h2, k[2:0], 3'h0, 3'h1, 16'h0F0F, 1'b0);
      r = k < 2 ? rv[4] : k < 5 ? 16'h0000 : 16'h0F0F;
      s = k == 7 ? 16'h0000 : (k == 4 || k == 5) ? rv[4] : k[0] ? rv[2] : 16'h1357;
      chk_alu(3'h0, r, s, 1'b0);
    end
    apb(1'b0, als_pkg::OFS_WORK, 32'h0);
    `CHK("work load", 16'h1357, rd[15:0]);
  endtask : test_src
  task automatic test_dst();
    run(4'h0, 4'h5, 3'h7, 3'h3, 3'h3, 16'h1111, 1'b0);
    run(4'h0, 4'h5, 3'h7, 3'h3, 3'h1, 16'hBEEF, 1'b0);
    rd_file(4'h5, 16'h1111);
    run(4'h4, 4'h5, 3'h7, 3'h3, 3'h2, 16'h2222, 1'b0);
    `CHK("bypass", rv[4], bus);
    rd_file(4'h5, 16'h2222);
    run(4'h5, 4'h5, 3'h5, 3'h0, 3'h3, 16'h0003, 1'b0);
    `CHK("rmw 1", 16'h2225, bus);
    run(4'h5, 4'h5, 3'h5, 3'h0, 3'h3, 16'h0003, 1'b0);
    `CHK("rmw 2", 16'h2228, bus);
    rd_file(4'h5, 16'h2228);
    @(posedge pclk) pin_drv <= 4'b0010;
    run(4'h0, 4'h6, 3'h7, 3'h3, 3'h5, 16'h0003, 1'b0);
    `CHK("down pins", 3'b011, {pin_oe[1:0], pin_o[0]});
    rd_file(4'h6, 16'h8001);
    @(posedge pclk) pin_drv <= 4'b0001;
    run(4'h0, 4'h6, 3'h7, 3'h3, 3'h7, 16'h8001, 1'b0);
    `CHK("up pins", 3'b101, {pin_oe[1:0], pin_o[1]});
    rd_file(4'h6, 16'h0003);
    @(posedge pclk) pin_drv <= 4'b1000;
    run(4'h0, 4'h6, 3'h7, 3'h3, 3'h4, 16'h0002, 1'b0);
    `CHK("work down pins", 3'b110, {pin_oe[2], pin_o[2], pin_oe[3]});
    rd_file(4'h6, 16'h0001);
    apb(1'b0, als_pkg::OFS_WORK, 32'h0);
    `CHK("work down", 16'h89AB, rd[15:0]);
    @(posedge pclk) pin_drv <= 4'b0000;
    run(4'h0, 4'h6, 3'h7, 3'h3, 3'h6, 16'h4000, 1'b0);
    `CHK("work up pins", 3'b110, {pin_oe[3], pin_o[3], pin_o[1]});
    rd_file(4'h6, 16'h8000);
    apb(1'b0, als_pkg::OFS_WORK, 32'h0);
    `CHK("work up", 16'h1356, rd[15:0]);
  endtask : test_dst
  task automatic test_regs();
    logic [31:0] st;
    apb(1'b0, als_pkg::OFS_CTRL, 32'h0);
    `CHK("ctrl reset", als_pkg::CTRL_RESET, rd);
    `CHK("mapped", 1'b0, err);
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, err);
    apb(1'b1, als_pkg::OFS_CTRL, 32'h0);
    run(4'h0, 4'h6, 3'h7, 3'h3, 3'h3, 16'h5555, 1'b0);
    run(4'h0, 4'h1, 3'h7, 3'h3, 3'h1, 16'h0000, 1'b0);
    apb(1'b1, als_pkg::OFS_CTRL, 32'h1);
    rd_file(4'h6, 16'h8000);
    @(posedge pclk) output_enable_n <= 1'b1;
    @(negedge pclk);
    `CHK("bus off", 1'b0, bus_oe);
    @(posedge pclk) output_enable_n <= 1'b0;
    @(negedge pclk);
    `CHK("bus on", 1'b1, bus_oe);
    // fields still stand: zero plus word 6 gives 0x8000, sign set, no carry
    apb(1'b0, als_pkg::OFS_RESULT, 32'h0);
    `CHK("result reg", 32'h0000_8000, rd);
    st = (32'h1 << als_pkg::ST_SIGN_BIT) | (32'h1 << als_pkg::ST_PROP_N_BIT) |
         (32'h1 << als_pkg::ST_GEN_N_BIT);
    apb(1'b0, als_pkg::OFS_STATUS, 32'h0);
    `CHK("status reg", st, rd);
  endtask : test_regs
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    $display("ERROR watchdog expected finish got timeout");
    test_done();
  end
  initial begin
    errors = 0; num_checks = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0; pin_drv = 4'h0; output_enable_n = 1'b0;
    rv[1] = 16'h7FFF; rv[2] = 16'h0001; rv[3] = 16'h8000; rv[4] = 16'hA5C3;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, als_pkg::OFS_WORK, 32'h0);
    `CHK("work reset", 32'h0, rd);
    test_alu();
    test_src();
    test_dst();
    test_regs();
    test_done();
  end
endmodule : sixteen_bit_alu_slice_tb
`default_nettype wire
